// >>> common/irq_prio_pkg.sv
package irq_prio_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned NUM_REGS = 7;
  localparam logic [3:0] IDX_EXT1 = 4'h0;
  localparam logic [3:0] IDX_TMR4_CMP34 = 4'h1;
  localparam logic [3:0] IDX_UART2_EXT2_TMR5 = 4'h2;
  localparam logic [3:0] IDX_SPI2 = 4'h3;
  localparam logic [3:0] IDX_CAP345 = 4'h4;
  localparam logic [3:0] IDX_CMP5 = 4'h5;
  localparam logic [3:0] IDX_PPORT = 4'h6;
  localparam logic [11:0] ADDR_EXT1 = 12'h000;
  localparam logic [11:0] ADDR_TMR4_CMP34 = 12'h004;
  localparam logic [11:0] ADDR_UART2_EXT2_TMR5 = 12'h008;
  localparam logic [11:0] ADDR_SPI2 = 12'h00c;
  localparam logic [11:0] ADDR_CAP345 = 12'h010;
  localparam logic [11:0] ADDR_CMP5 = 12'h014;
  localparam logic [11:0] ADDR_PPORT = 12'h018;

  // field low-bit positions
  localparam int unsigned POS_F0 = 0;
  localparam int unsigned POS_F1 = 4;
  localparam int unsigned POS_F2 = 8;
  localparam int unsigned POS_F3 = 12;

  // implemented-bit masks per register
  localparam logic [15:0] MASK_EXT1 = 16'h0007;
  localparam logic [15:0] MASK_TMR4_CMP34 = 16'h7770;
  localparam logic [15:0] MASK_UART2_EXT2_TMR5 = 16'h7777;
  localparam logic [15:0] MASK_SPI2 = 16'h0077;
  localparam logic [15:0] MASK_CAP345 = 16'h7770;
  localparam logic [15:0] MASK_CMP5 = 16'h0070;
  localparam logic [15:0] MASK_PPORT = 16'h0070;

  // every field resets to level 4; fill pattern before masking
  localparam logic [2:0] FIELD_RESET = 3'h4;
  localparam logic [15:0] RESET_FILL = 16'h4444;
  localparam logic [2:0] CODE_DISABLED = 3'h0;

endpackage : irq_prio_pkg

// >>> design/prio_reg16.sv
`timescale 1ns/1ns
`default_nettype none
module prio_reg16 #(
  parameter logic [15:0] MASK = 16'h0000,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // stored value
  output logic [15:0] value
);
  logic [15:0] value_q;
  logic [15:0] value_d;

  // unimplemented bits never store anything
  assign value_d = wr_en ? (wr_data & MASK) : value_q;
  assign value = value_q & MASK;

  always_ff @(posedge clk) begin
    if (srst) begin
      value_q <= RESET_VAL & MASK;
    end else begin
      value_q <= value_d;
    end
  end
endmodule : prio_reg16
`default_nettype wire

// >>> design/prio_level_decode.sv
`timescale 1ns/1ns
`default_nettype none
module prio_level_decode (
  // field code
  input wire logic [2:0] code,
  // decoded request view
  output logic enabled,
  output logic [2:0] level
);
  // code is the level itself: 000 off, 001 lowest, 111 highest
  assign enabled = (code != irq_prio_pkg::CODE_DISABLED);
  assign level = code;
endmodule : prio_level_decode
`default_nettype wire

// >>> design/irq_priority_config_bank.sv
// Overview of operation
// - code 111 gives level 7, highest
// - code 000 disables the source
// - code 001 gives level 1, lowest
// - unassigned bits ignore writes, read zero
// - field bits read back last written
// - every field resets to 100
// - reg 0: ext irq1 in bits 2:0
// - reg 1: timer4 14:12, cmp4 10:8, cmp3 6:4
// - reg 2: serial2 tx 14:12, rx 10:8
// - reg 2: ext irq2 6:4, timer5 2:0
// - reg 3: spi2 event 6:4, fault 2:0
// - reg 4: capture 5/4/3 at 14:12/10:8/6:4
// - reg 5: compare5 in bits 6:4
// - reg 6: parallel port in bits 6:4
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module irq_priority_config_bank (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // priority fields to arbitration
  output logic [2:0] ext_irq1_level,
  output logic [2:0] timer_four_level,
  output logic [2:0] compare_ch4_level,
  output logic [2:0] compare_ch3_level,
  output logic [2:0] serial2_tx_level,
  output logic [2:0] serial2_rx_level,
  output logic [2:0] ext_irq2_level,
  output logic [2:0] timer_five_level,
  output logic [2:0] spi_port2_event_level,
  output logic [2:0] spi_port2_fault_level,
  output logic [2:0] capture_ch5_level,
  output logic [2:0] capture_ch4_level,
  output logic [2:0] capture_ch3_level,
  output logic [2:0] compare_ch5_level,
  output logic [2:0] parallel_port_level,
  // per-source enable, low when code is 000
  output logic [14:0] source_enabled
);
  localparam int unsigned NSRC = 15;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_state_e;

  apb_state_e state_q;
  apb_state_e state_d;

  // implemented masks and register index lookup
  function automatic logic [15:0] reg_mask(input logic [3:0] idx);
    case (idx)
      irq_prio_pkg::IDX_EXT1: reg_mask = irq_prio_pkg::MASK_EXT1;
      irq_prio_pkg::IDX_TMR4_CMP34: reg_mask = irq_prio_pkg::MASK_TMR4_CMP34;
      irq_prio_pkg::IDX_UART2_EXT2_TMR5: reg_mask = irq_prio_pkg::MASK_UART2_EXT2_TMR5;
      irq_prio_pkg::IDX_SPI2: reg_mask = irq_prio_pkg::MASK_SPI2;
      irq_prio_pkg::IDX_CAP345: reg_mask = irq_prio_pkg::MASK_CAP345;
      irq_prio_pkg::IDX_CMP5: reg_mask = irq_prio_pkg::MASK_CMP5;
      irq_prio_pkg::IDX_PPORT: reg_mask = irq_prio_pkg::MASK_PPORT;
      default: reg_mask = 16'h0000;
    endcase
  endfunction : reg_mask

  // decode
  wire logic [3:0] addr_idx = paddr[5:2];
  wire logic addr_hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
                        && (addr_idx < 4'h7);
  wire logic access = psel && penable && (state_q == ST_IDLE);
  // writes land on the edge that samples pready, never a cycle early
  wire logic complete_phase = psel && penable && (state_q == ST_DONE);
  wire logic wr_fire = complete_phase && pwrite && addr_hit;
  // byte lanes: only the low two bytes hold fields
  wire logic [15:0] strb_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  logic [15:0] reg_val [irq_prio_pkg::NUM_REGS];
  logic [15:0] wr_merge [irq_prio_pkg::NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NUM_REGS; g++) begin : g_reg
      localparam logic [3:0] GIDX = 4'(g);
      // partial strobes keep the untouched lane
      assign wr_merge[g] = (pwdata[15:0] & strb_mask) | (reg_val[g] & ~strb_mask);
      prio_reg16 #(
        .MASK(reg_mask(GIDX)),
        .RESET_VAL(irq_prio_pkg::RESET_FILL)
      ) u_reg (
        .clk(clk),
        .srst(srst),
        .wr_en(wr_fire && (addr_idx == GIDX)),
        .wr_data(wr_merge[g]),
        .value(reg_val[g])
      );
    end
  endgenerate

  // field extraction, placed per register layout
  wire logic [2:0] fld [NSRC];
  assign fld[0] = reg_val[0][irq_prio_pkg::POS_F0 +: 3];
  assign fld[1] = reg_val[1][irq_prio_pkg::POS_F3 +: 3];
  assign fld[2] = reg_val[1][irq_prio_pkg::POS_F2 +: 3];
  assign fld[3] = reg_val[1][irq_prio_pkg::POS_F1 +: 3];
  assign fld[4] = reg_val[2][irq_prio_pkg::POS_F3 +: 3];
  assign fld[5] = reg_val[2][irq_prio_pkg::POS_F2 +: 3];
  assign fld[6] = reg_val[2][irq_prio_pkg::POS_F1 +: 3];
  assign fld[7] = reg_val[2][irq_prio_pkg::POS_F0 +: 3];
  assign fld[8] = reg_val[3][irq_prio_pkg::POS_F1 +: 3];
  assign fld[9] = reg_val[3][irq_prio_pkg::POS_F0 +: 3];
  assign fld[10] = reg_val[4][irq_prio_pkg::POS_F3 +: 3];
  assign fld[11] = reg_val[4][irq_prio_pkg::POS_F2 +: 3];
  assign fld[12] = reg_val[4][irq_prio_pkg::POS_F1 +: 3];
  assign fld[13] = reg_val[5][irq_prio_pkg::POS_F1 +: 3];
  assign fld[14] = reg_val[6][irq_prio_pkg::POS_F1 +: 3];

  logic [2:0] lvl [NSRC];
  logic [NSRC-1:0] en_d;
  generate
    for (g = 0; g < NSRC; g++) begin : g_dec
      prio_level_decode u_dec (
        .code(fld[g]),
        .enabled(en_d[g]),
        .level(lvl[g])
      );
    end
  endgenerate

  // registered copies so outputs come from flops; one cycle after a write
  logic [2:0] lvl_q [NSRC];
  logic [NSRC-1:0] en_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NSRC; i++) begin
        lvl_q[i] <= irq_prio_pkg::FIELD_RESET;
      end
      en_q <= '1;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        lvl_q[i] <= lvl[i];
      end
      en_q <= en_d;
    end
  end

  assign ext_irq1_level = lvl_q[0];
  assign timer_four_level = lvl_q[1];
  assign compare_ch4_level = lvl_q[2];
  assign compare_ch3_level = lvl_q[3];
  assign serial2_tx_level = lvl_q[4];
  assign serial2_rx_level = lvl_q[5];
  assign ext_irq2_level = lvl_q[6];
  assign timer_five_level = lvl_q[7];
  assign spi_port2_event_level = lvl_q[8];
  assign spi_port2_fault_level = lvl_q[9];
  assign capture_ch5_level = lvl_q[10];
  assign capture_ch4_level = lvl_q[11];
  assign capture_ch3_level = lvl_q[12];
  assign compare_ch5_level = lvl_q[13];
  assign parallel_port_level = lvl_q[14];
  assign source_enabled = en_q;

  // apb answer: one wait state, pready in the second access cycle
  wire logic [15:0] rd_word = addr_hit ? reg_val[addr_idx[2:0]] : 16'h0000;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (access) state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pready_q <= access;
      pslverr_q <= access && !addr_hit;
      prdata_q <= (access && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : irq_priority_config_bank
`default_nettype wire

// >>> verification/irq_prio_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module irq_prio_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // fields
  input wire logic [2:0] ext_irq1_level,
  input wire logic [2:0] parallel_port_level,
  input wire logic [14:0] source_enabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_answer; s_setup ##1 s_access |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("refused access not clean");
  property p_upper; prdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_en0; source_enabled[0] == (ext_irq1_level != 3'h0); endproperty
  a_en0: assert property (p_en0) else $error("enable bit 0 wrong");
  property p_en14; source_enabled[14] == (parallel_port_level != 3'h0); endproperty
  a_en14: assert property (p_en14) else $error("enable bit 14 wrong");
  property p_chg; $changed(parallel_port_level) |-> $past(pready && pwrite, 2); endproperty
  a_chg: assert property (p_chg) else $error("level changed without write");
  property p_rst;
    disable iff (1'b0) srst ##1 srst |=> ext_irq1_level == 3'h4 && parallel_port_level == 3'h4;
  endproperty
  a_rst: assert property (p_rst) else $error("reset level not 4");
endmodule : irq_prio_assertions
bind irq_priority_config_bank irq_prio_assertions u_chk (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_irq1_level(ext_irq1_level),
  .parallel_port_level(parallel_port_level), .source_enabled(source_enabled));
`default_nettype wire

// >>> verification/tb_irq_priority_config_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_irq_priority_config_bank;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] lv [15];
  logic [14:0] source_enabled;
  logic [31:0] rd;
  logic er;
  logic [2:0] c;
  logic [2:0] ex [15] = '{3'h1, 3'h7, 3'h5, 3'h3, 3'h7, 3'h5, 3'h3, 3'h1, 3'h3, 3'h1,
    3'h7, 3'h5, 3'h3, 3'h3, 3'h3};
  logic [15:0] pat [3] = '{16'hffff, 16'h7531, 16'h0000};
  logic [15:0] msk [7];
  int err_total = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  irq_priority_config_bank u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq1_level(lv[0]), .timer_four_level(lv[1]),
    .compare_ch4_level(lv[2]), .compare_ch3_level(lv[3]), .serial2_tx_level(lv[4]),
    .serial2_rx_level(lv[5]), .ext_irq2_level(lv[6]), .timer_five_level(lv[7]),
    .spi_port2_event_level(lv[8]), .spi_port2_fault_level(lv[9]),
    .capture_ch5_level(lv[10]), .capture_ch4_level(lv[11]), .capture_ch3_level(lv[12]),
    .compare_ch5_level(lv[13]), .parallel_port_level(lv[14]),
    .source_enabled(source_enabled));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // read data and error are taken at the edge that samples pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input int i, input logic [15:0] e);
    apb(12'(i * 4), 1'b0, 32'h0);
    check(rd, {16'h0, e});
    check({31'h0, er}, 32'h0);
  endtask : rdchk
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    msk = '{irq_prio_pkg::MASK_EXT1, irq_prio_pkg::MASK_TMR4_CMP34,
      irq_prio_pkg::MASK_UART2_EXT2_TMR5, irq_prio_pkg::MASK_SPI2, irq_prio_pkg::MASK_CAP345,
      irq_prio_pkg::MASK_CMP5, irq_prio_pkg::MASK_PPORT};
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) rdchk(i, 16'h4444 & msk[i]);
    for (int p = 0; p < 3; p++) begin
      // upper half written with ones to show it is dropped
      for (int i = 0; i < 7; i++) begin
        apb(12'(i * 4), 1'b1, {16'hffff, pat[p]});
        rdchk(i, pat[p] & msk[i]);
      end
      repeat (2) @(negedge clk);
      for (int j = 0; j < 15; j++) begin
        c = (p == 0) ? 3'h7 : ((p == 2) ? 3'h0 : ex[j]);
        check({29'h0, lv[j]}, {29'h0, c});
      end
      check({17'h0, source_enabled}, {17'h0, {15{p != 2}}});
    end
    @(posedge clk);
    pstrb <= 4'h1;
    apb(12'h008, 1'b1, 32'h0000ffff);
    pstrb <= 4'hf;
    rdchk(2, 16'h0077);
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      apb(12'h008, 1'b1, {16'h0, 1'b0, c, 1'b0, c, 1'b0, c, 1'b0, c});
      repeat (2) @(negedge clk);
      check({20'h0, lv[4], lv[5], lv[6], lv[7]}, {20'h0, c, c, c, c});
      check({28'h0, source_enabled[7:4]}, {28'h0, {4{c != 3'h0}}});
    end
    apb(12'h01c, 1'b0, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    apb(12'h000, 1'b1, 32'h0000ffff);
    apb(12'h002, 1'b1, 32'h0);
    check({31'h0, er}, 32'h1);
    rdchk(0, 16'h0007);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdchk(2, 16'h4444);
    print_verdict();
  end
endmodule : tb_irq_priority_config_bank
`default_nettype wire
